// *** logic/hiu_top.sv ***
// Host interface unit: strobe capture, lane decode, local select
//
// Contract
// (R1) Synchronous accesses use the host bus clock, max 50 MHz, 32-bit only.
// (R2) Bus clock times synchronous transfers; asynchronous ones ignore it.
// (R3) Host never overlaps synchronous and asynchronous transfers.
// (R4) On 32-bit bus accept byte, half and word transfers.
// (R5) On 16-bit bus accept byte and half transfers only.
// (R6) An 8-bit host issues single-byte transfers only.
// (R7) No byte swap; 8-bit host wires its byte to lanes 0 and 1.
// (R8) A 16-bit host leaves the upper two lanes unconnected.
// (R9) Decode only while qualifier low; high means DMA, ignored.
// (R10) All selects low is a word access, 32-bit bus only.
// (R11) Selects 0,1 low, 2,3 high: lower half access.
// (R12) Selects 0,1 high, 2,3 low: upper half access.
// (R13) Only select 0 low: byte access on lane 0.
// (R14) Single select low picks that byte lane; lanes 2,3 need 32-bit.
// (R15) Address, qualifier and selects latch at address strobe rising edge.
// (R16) Local select is combinational decode of qualifier and A[15:4] vs base.
// (R17) Queue select in 32-bit mode bypasses decode: word access to queue.
// (R18) Unlisted select patterns access nothing and leave data undriven.
// (R19) Upper-lane patterns are invalid on 16-bit or 8-bit bus.
`timescale 1ns/1ps
module hiu_top (
   // System clock and reset
   input  wire logic        clock_in,
   input  wire logic        rst_b_in,
   // Host bus clock for synchronous transfers
   input  wire logic        bus_clock_in,
   // Straps
   input  wire logic        sync_mode_in,
   input  wire logic [1:0]  bus_width_in,
   input  wire logic [11:0] base_addr_in,
   // Host common signals
   input  wire logic [15:1] address_in,
   input  wire logic        address_qualifier_low_in,
   input  wire logic        lane_select_zero_n_in,
   input  wire logic        lane_select_one_n_in,
   input  wire logic        lane_select_two_n_in,
   input  wire logic        lane_select_three_n_in,
   input  wire logic        address_strobe_n_in,
   input  wire logic        write_n_in,
   input  wire logic        read_strobe_n_in,
   input  wire logic        queue_data_select_n_in,
   // Host data lines
   output logic [31:0]      host_data_lines_out,
   output logic [3:0]       host_data_lines_oe_n_out,
   // Local device select
   output logic             local_select_out_n,
   // Core side
   input  wire logic [31:0] read_data_in,
   output logic             access_pulse_out,
   output logic [1:0]       access_size_out,
   output logic [3:0]       access_lanes_out,
   output logic [14:0]      access_addr_out,
   output logic             access_write_out,
   output logic             queue_access_out,
   output logic [1:0]       bus_width_out
);
   hiu_pkg::hiu_req_t  pin_req;
   hiu_pkg::hiu_req_t  bclk_word_q;
   hiu_pkg::hiu_req_t  async_req_s;
   hiu_pkg::hiu_req_t  async_req_q;
   hiu_pkg::hiu_req_t  cur_req;
   logic               bclk_strobe_q;
   logic               bclk_tog_q;
   logic               bclk_mode_s;
   logic               bclk_rise;
   logic               tog_s;
   logic               tog_seen_q;
   logic               async_strobe_s;
   logic               async_strobe_q;
   logic               mode_s;
   logic               rd_strobe_s;
   logic [1:0]         width_s;
   logic [1:0]         strap_cnt_q;
   hiu_pkg::hiu_width_t width_q;
   logic               sync_ev;
   logic               async_ev;
   logic               cap_ev;

   assign pin_req.addr    = address_in;
   assign pin_req.qual    = address_qualifier_low_in;
   assign pin_req.lanes_n = {lane_select_three_n_in, lane_select_two_n_in,
                             lane_select_one_n_in, lane_select_zero_n_in};
   assign pin_req.write_n = write_n_in;
   assign pin_req.queue_n = queue_data_select_n_in;

   // Local select from live pins, no register [R16]
   assign local_select_out_n = ~(~address_qualifier_low_in && (address_in[15:4] == base_addr_in));

   // Bus clock domain capture, synchronous mode only [R1] [R2]
   hiu_sync2 #(.WIDTH(1), .RST_VAL(1'b0)) u_bmode (
      .clock_in  (bus_clock_in),
      .rst_b_in  (rst_b_in),
      .level_in  (sync_mode_in),
      .level_out (bclk_mode_s)
   );
   assign bclk_rise = ~bclk_strobe_q & address_strobe_n_in & bclk_mode_s;   // [R15]

   always_ff @(posedge bus_clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         bclk_strobe_q <= 1'b1;
         bclk_tog_q    <= 1'b0;
         bclk_word_q   <= '1;
      end
      else
      begin
         bclk_strobe_q <= address_strobe_n_in;
         if (bclk_rise)
         begin
            bclk_word_q <= pin_req;   // [R15]
            bclk_tog_q  <= ~bclk_tog_q;
         end
      end
   end

   // Toggle crossing into system clock; word is stable while toggle settles
   hiu_sync2 #(.WIDTH(1), .RST_VAL(1'b0)) u_tog (
      .clock_in  (clock_in),
      .rst_b_in  (rst_b_in),
      .level_in  (bclk_tog_q),
      .level_out (tog_s)
   );

   // Asynchronous path, strobe and request synchronised together [R2]
   hiu_sync2 #(.WIDTH(1 + hiu_pkg::HIU_REQ_W), .RST_VAL('1)) u_async (
      .clock_in  (clock_in),
      .rst_b_in  (rst_b_in),
      .level_in  ({address_strobe_n_in, pin_req}),
      .level_out ({async_strobe_s, async_req_s})
   );
   hiu_sync2 #(.WIDTH(4), .RST_VAL(4'hF)) u_misc (
      .clock_in  (clock_in),
      .rst_b_in  (rst_b_in),
      .level_in  ({sync_mode_in, read_strobe_n_in, bus_width_in}),
      .level_out ({mode_s, rd_strobe_s, width_s})
   );

   // One source at a time; host keeps the two kinds apart [R3]
   assign sync_ev  = (tog_s != tog_seen_q) & mode_s;
   assign async_ev = ~async_strobe_q & async_strobe_s & ~mode_s;   // [R15]
   assign cap_ev   = sync_ev | async_ev;
   assign cur_req  = sync_ev ? bclk_word_q : async_req_s;

   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         tog_seen_q     <= 1'b0;
         async_strobe_q <= 1'b1;
         async_req_q    <= '1;
      end
      else
      begin
         tog_seen_q     <= tog_s;
         async_strobe_q <= async_strobe_s;
         if (cap_ev)
         begin
            async_req_q <= cur_req;
         end
      end
   end

   // Width strap caught once the synchroniser has filled
   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         strap_cnt_q <= 2'h0;
         width_q     <= hiu_pkg::HIU_W8;
      end
      else if (strap_cnt_q != hiu_pkg::HIU_STRAP_CNT_DONE)
      begin
         strap_cnt_q <= strap_cnt_q + 2'h1;
         if (strap_cnt_q == hiu_pkg::HIU_STRAP_CNT_DONE - 2'h1)
         begin
            width_q <= hiu_pkg::hiu_width_t'(width_s);
         end
      end
   end

   // Lane pattern decode
   wire is32     = (width_q == hiu_pkg::HIU_W32);
   wire queue    = is32 & ~cur_req.queue_n;                        // [R17]
   wire qual_ok  = ~cur_req.qual;                                  // [R9]
   wire [3:0] ln = cur_req.lanes_n;
   wire pat_word = (ln == hiu_pkg::HIU_BE_WORD) & is32;            // [R10] [R4] [R5]
   wire pat_lo   = (ln == hiu_pkg::HIU_BE_LO);                     // [R11]
   wire pat_hi   = (ln == hiu_pkg::HIU_BE_HI) & is32;              // [R12] [R19]
   wire pat_b01  = (ln == hiu_pkg::HIU_BE_B0) | (ln == hiu_pkg::HIU_BE_B1);   // [R13] [R14]
   wire pat_b23  = ((ln == hiu_pkg::HIU_BE_B2) | (ln == hiu_pkg::HIU_BE_B3)) & is32;   // [R14] [R19]
   wire pat_ok   = qual_ok & (pat_word | pat_lo | pat_hi | pat_b01 | pat_b23);   // [R18]
   wire [1:0] dec_size  = queue ? hiu_pkg::HIU_SZ_WORD :
                          ~pat_ok ? hiu_pkg::HIU_SZ_NONE :
                          pat_word ? hiu_pkg::HIU_SZ_WORD :
                          (pat_lo | pat_hi) ? hiu_pkg::HIU_SZ_HALF : hiu_pkg::HIU_SZ_BYTE;
   wire [3:0] dec_lanes = queue ? hiu_pkg::HIU_LANES_ALL :
                          pat_ok ? ~ln : hiu_pkg::HIU_LANES_RST;

   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         access_pulse_out <= 1'b0;
         access_size_out  <= hiu_pkg::HIU_SZ_NONE;
         access_lanes_out <= hiu_pkg::HIU_LANES_RST;
         access_addr_out  <= hiu_pkg::HIU_ADDR_RST;
         access_write_out <= 1'b0;
         queue_access_out <= 1'b0;
      end
      else
      begin
         access_pulse_out <= cap_ev & (queue | pat_ok);
         if (cap_ev)
         begin
            access_size_out  <= dec_size;
            access_lanes_out <= dec_lanes;
            access_addr_out  <= cur_req.addr;
            access_write_out <= ~cur_req.write_n;
            queue_access_out <= queue;
         end
      end
   end

   // Read drive only on decoded lanes; lane wiring is the host's [R7] [R8]
   wire       rd_active = ~rd_strobe_s & ~access_write_out;
   wire [3:0] drive_en  = access_lanes_out & {4{rd_active}};     // [R18]
   wire [31:0] lane_mask;
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_lane
         assign lane_mask[g*8 +: 8] = {8{drive_en[g]}};
      end
   endgenerate

   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         host_data_lines_out      <= hiu_pkg::HIU_DATA_RST;
         host_data_lines_oe_n_out <= hiu_pkg::HIU_OE_N_RST;
         bus_width_out            <= hiu_pkg::HIU_W8;
      end
      else
      begin
         host_data_lines_out      <= read_data_in & lane_mask;
         host_data_lines_oe_n_out <= ~drive_en;
         bus_width_out            <= width_q;
      end
   end

   // Checks
   chk_dma_cycle_ignored: assert property (@(posedge clock_in) disable iff (!rst_b_in)   // [R9]
      cap_ev && cur_req.qual && !queue |=> !access_pulse_out && access_size_out == hiu_pkg::HIU_SZ_NONE)
      else $error("DMA cycle was decoded");
   chk_word_needs_wide: assert property (@(posedge clock_in) disable iff (!rst_b_in)   // [R10]
      access_pulse_out && access_size_out == hiu_pkg::HIU_SZ_WORD |-> bus_width_out == hiu_pkg::HIU_W32)
      else $error("Word access on narrow bus");
   chk_queue_word_access: assert property (@(posedge clock_in) disable iff (!rst_b_in)   // [R17]
      cap_ev && queue |=> access_size_out == hiu_pkg::HIU_SZ_WORD && access_lanes_out == 4'hF && queue_access_out)
      else $error("Queue select not a word access");
   chk_lower_half_lanes: assert property (@(posedge clock_in) disable iff (!rst_b_in)   // [R11]
      cap_ev && !queue && qual_ok && ln == hiu_pkg::HIU_BE_LO |=> access_lanes_out == 4'h3)
      else $error("Lower half lanes wrong");
   chk_upper_half_lanes: assert property (@(posedge clock_in) disable iff (!rst_b_in)   // [R12]
      cap_ev && !queue && qual_ok && is32 && ln == hiu_pkg::HIU_BE_HI |=> access_lanes_out == 4'hC)
      else $error("Upper half lanes wrong");
   chk_byte_zero_lane: assert property (@(posedge clock_in) disable iff (!rst_b_in)   // [R13]
      cap_ev && !queue && qual_ok && ln == hiu_pkg::HIU_BE_B0
      |=> access_lanes_out == 4'h1 && access_size_out == hiu_pkg::HIU_SZ_BYTE)
      else $error("Byte zero lane wrong");
   chk_narrow_upper_bad: assert property (@(posedge clock_in) disable iff (!rst_b_in)   // [R19]
      cap_ev && !is32 && (ln == hiu_pkg::HIU_BE_B2 || ln == hiu_pkg::HIU_BE_B3) |=> !access_pulse_out)
      else $error("Upper lane accepted on narrow bus");
   chk_invalid_undriven: assert property (@(posedge clock_in) disable iff (!rst_b_in)   // [R18]
      access_lanes_out == 4'h0 ##1 access_lanes_out == 4'h0 |-> host_data_lines_oe_n_out == 4'hF)
      else $error("Data driven without valid lanes");
   chk_sync_capture_toggle: assert property (@(posedge bus_clock_in) disable iff (!rst_b_in)   // [R2]
      bclk_rise |=> bclk_tog_q != $past(bclk_tog_q) && bclk_word_q == $past(pin_req))
      else $error("Synchronous strobe edge not captured");
   cov_word_access: cover property (@(posedge clock_in) disable iff (!rst_b_in)
      access_pulse_out && access_size_out == hiu_pkg::HIU_SZ_WORD);
   cov_byte_three: cover property (@(posedge clock_in) disable iff (!rst_b_in)
      access_pulse_out && access_lanes_out == 4'h8);
   cov_queue_access: cover property (@(posedge clock_in) disable iff (!rst_b_in)
      access_pulse_out && queue_access_out);
   cov_sync_event: cover property (@(posedge clock_in) disable iff (!rst_b_in) sync_ev);
endmodule

// *** logic/hiu_pkg.sv ***
// Shared types and constants of the host interface unit
package hiu_pkg;
   // Bus width strap encodings
   typedef enum logic [1:0] {
      HIU_W8  = 2'b00,
      HIU_W16 = 2'b01,
      HIU_W32 = 2'b10
   } hiu_width_t;

   // Decoded transfer size
   typedef enum logic [1:0] {
      HIU_SZ_NONE = 2'b00,
      HIU_SZ_BYTE = 2'b01,
      HIU_SZ_HALF = 2'b10,
      HIU_SZ_WORD = 2'b11
   } hiu_size_t;

   // Request latched at the address strobe
   typedef struct packed {
      logic [14:0] addr;
      logic        qual;
      logic [3:0]  lanes_n;
      logic        write_n;
      logic        queue_n;
   } hiu_req_t;

   localparam int unsigned HIU_REQ_W        = $bits(hiu_req_t);
   localparam int unsigned HIU_CLK_MHZ      = 200;
   localparam int unsigned HIU_BUS_CLK_MAX_MHZ = 50;
   localparam int unsigned HIU_SYNC_STAGES  = 2;

   // Active-low lane select patterns and active-high all-lanes mask, bit 0 is lane zero
   localparam logic [3:0] HIU_BE_WORD = 4'h0;
   localparam logic [3:0] HIU_BE_LO   = 4'hC;
   localparam logic [3:0] HIU_BE_HI   = 4'h3;
   localparam logic [3:0] HIU_BE_B0   = 4'hE;
   localparam logic [3:0] HIU_BE_B1   = 4'hD;
   localparam logic [3:0] HIU_BE_B2   = 4'hB;
   localparam logic [3:0] HIU_BE_B3   = 4'h7;
   localparam logic [3:0] HIU_LANES_ALL = 4'hF;

   // Reset values and strap counter end count
   localparam logic [3:0]  HIU_LANES_RST = 4'h0;
   localparam logic [3:0]  HIU_OE_N_RST  = 4'hF;
   localparam logic [31:0] HIU_DATA_RST  = 32'h0000_0000;
   localparam logic [14:0] HIU_ADDR_RST  = 15'h0000;
   localparam logic [1:0]  HIU_STRAP_CNT_DONE = 2'h3;
endpackage

// *** logic/hiu_sync2.sv ***
// Two-flop level synchroniser
`timescale 1ns/1ps
module hiu_sync2 #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic             clock_in,
   input  wire logic             rst_b_in,
   // Data
   input  wire logic [WIDTH-1:0] level_in,
   output logic      [WIDTH-1:0] level_out
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         meta_q    <= RST_VAL;
         level_out <= RST_VAL;
      end
      else
      begin
         meta_q    <= level_in;
         level_out <= meta_q;
      end
   end
endmodule

// *** verif/hiu_host_model.sv ***
// Host processor model driving the shared host bus signals
`timescale 1ns/1ps
module hiu_host_model (
   // Clocks and mode
   input  wire logic        clock_in,
   input  wire logic        bus_clock_in,
   input  wire logic        sync_mode_in,
   // Host pins
   output logic [15:1]      address_out,
   output logic             qual_out,
   output logic [3:0]       lanes_n_out,
   output logic             strobe_n_out,
   output logic             write_n_out,
   output logic             read_n_out,
   output logic             queue_n_out
);
   initial
   begin
      {address_out, qual_out, lanes_n_out} = {15'h0000, 1'b1, 4'hF};
      {strobe_n_out, write_n_out, read_n_out, queue_n_out} = 4'hF;
   end

   // One transfer at a time, never overlapped
   task automatic access(input logic [14:0] a, input logic q, input logic [3:0] ln, input logic wn,
                         input logic qn);
      @(posedge clock_in);
      strobe_n_out <= 1'b0;
      address_out  <= ~a;
      if (sync_mode_in)
         @(posedge bus_clock_in);
      else
         repeat (4) @(posedge clock_in);
      @(posedge clock_in);
      // Final values settle before the strobe rise; in synchronous mode they change with it
      {address_out, qual_out, lanes_n_out, write_n_out, queue_n_out} <= {a, q, ln, wn, qn};
      if (!sync_mode_in)
         repeat (4) @(posedge clock_in);
      strobe_n_out <= 1'b1;
      if (sync_mode_in)
         @(posedge bus_clock_in);
      repeat (4) @(posedge clock_in);
      // Released lines show the inverse
      {address_out, qual_out, lanes_n_out} <= {a ^ 15'h7FFF, ~q, ~ln};
   endtask

   task automatic read_strobe(input logic v);
      @(posedge clock_in);
      read_n_out <= v;
   endtask

   task automatic drive_addr(input logic [14:0] a, input logic q);
      @(posedge clock_in);
      address_out <= a;
      qual_out    <= q;
   endtask
endmodule

// *** verif/host_bus_interface_decode_tb_top.sv ***
// Testbench for the host interface unit decode
`timescale 1ns/1ps
module host_bus_interface_decode_tb_top;
   logic        clock_in     = 1'b0;
   logic        rst_b_in     = 1'b0;
   logic        bus_clock_in = 1'b0;
   logic        sync_mode_in = 1'b0;
   logic [1:0]  bus_width_in = 2'h2;
   logic [11:0] base_addr_in = 12'h000;
   logic [31:0] read_data_in = 32'h0000_0000;
   logic [15:1] address;
   logic [3:0]  lanes_n;
   logic        qual, strobe_n, write_n, read_n, queue_n;
   logic [31:0] data_out;
   logic [3:0]  oe_n, lanes;
   logic [1:0]  size, width;
   logic [14:0] addr;
   logic        local_n, pulse, write, queue;
   int          failures = 0;
   int          n_tests = 0;
   int          cycles = 0;
   int          pulses = 0;

   always #2.5 clock_in = ~clock_in;
   initial
   begin
      #33.3;
      forever #80 bus_clock_in = ~bus_clock_in;
   end

   hiu_host_model host_u (.clock_in(clock_in), .bus_clock_in(bus_clock_in), .sync_mode_in(sync_mode_in),
      .address_out(address), .qual_out(qual), .lanes_n_out(lanes_n), .strobe_n_out(strobe_n),
      .write_n_out(write_n), .read_n_out(read_n), .queue_n_out(queue_n));

   hiu_top dut_u (.clock_in(clock_in), .rst_b_in(rst_b_in), .bus_clock_in(bus_clock_in),
      .sync_mode_in(sync_mode_in), .bus_width_in(bus_width_in), .base_addr_in(base_addr_in),
      .address_in(address), .address_qualifier_low_in(qual), .lane_select_zero_n_in(lanes_n[0]),
      .lane_select_one_n_in(lanes_n[1]), .lane_select_two_n_in(lanes_n[2]),
      .lane_select_three_n_in(lanes_n[3]), .address_strobe_n_in(strobe_n), .write_n_in(write_n),
      .read_strobe_n_in(read_n), .queue_data_select_n_in(queue_n), .host_data_lines_out(data_out),
      .host_data_lines_oe_n_out(oe_n), .local_select_out_n(local_n), .read_data_in(read_data_in),
      .access_pulse_out(pulse), .access_size_out(size), .access_lanes_out(lanes),
      .access_addr_out(addr), .access_write_out(write), .queue_access_out(queue), .bus_width_out(width));

   always @(posedge clock_in)
   begin
      if (pulse === 1'b1)
         pulses <= pulses + 1;
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         failures++;
         summarize();
      end
   end

   function automatic logic [3:0] exp_lanes(input logic [3:0] p, input logic q, input logic qn);
      logic w32;
      w32 = (bus_width_in == hiu_pkg::HIU_W32);
      if (w32 && !qn)
         return 4'hF;
      if (q)
         return 4'h0;
      case (p)
         4'h0:    return w32 ? 4'hF : 4'h0;
         4'hC:    return 4'h3;
         4'h3:    return w32 ? 4'hC : 4'h0;
         4'hE:    return 4'h1;
         4'hD:    return 4'h2;
         4'hB:    return w32 ? 4'h4 : 4'h0;
         4'h7:    return w32 ? 4'h8 : 4'h0;
         default: return 4'h0;
      endcase
   endfunction

   function automatic logic [1:0] exp_size(input logic [3:0] l);
      case (l)
         4'h0:       return hiu_pkg::HIU_SZ_NONE;
         4'h3, 4'hC: return hiu_pkg::HIU_SZ_HALF;
         4'hF:       return hiu_pkg::HIU_SZ_WORD;
         default:    return hiu_pkg::HIU_SZ_BYTE;
      endcase
   endfunction

   task automatic chk(input bit ok, input string what);
      n_tests++;
      if (!ok)
      begin
         failures++;
         $display("[ERR] %0t %s", $time, what);
      end
   endtask

   task automatic do_reset(input logic s, input logic [1:0] w);
      @(posedge clock_in);
      rst_b_in     <= 1'b0;
      sync_mode_in <= s;
      bus_width_in <= w;
      repeat (2) @(posedge bus_clock_in);
      chk(oe_n === 4'hF && pulse === 1'b0, "reset outputs");
      @(negedge clock_in);
      rst_b_in <= 1'b1;
      repeat (2) @(posedge bus_clock_in);
      repeat (4) @(posedge clock_in);
      #1;
      chk(width === w, "width strap");
   endtask

   task automatic do_access(input logic [14:0] a, input logic q, input logic [3:0] ln, input logic wn,
                            input logic qn);
      logic [3:0] el;
      int         p0;
      el = exp_lanes(ln, q, qn);
      p0 = pulses;
      @(posedge clock_in);
      read_data_in <= {a, 2'h2, ~a};
      host_u.access(a, q, ln, wn, qn);
      repeat (3) @(posedge clock_in);
      #1;
      chk(pulses == p0 + int'(el != 4'h0), "pulse count");
      chk(lanes === el, "lanes");
      chk(size === exp_size(el), "size");
      if (el != 4'h0)
      begin
         chk(addr === a && write === !wn, "addr or write");
         chk(queue === (!qn && bus_width_in == hiu_pkg::HIU_W32), "queue");
      end
      if (wn)
      begin
         host_u.read_strobe(1'b0);
         repeat (5) @(posedge clock_in);
         #1;
         chk(oe_n === ~el, "drive lanes");
         chk(data_out === (read_data_in & {{8{el[3]}}, {8{el[2]}}, {8{el[1]}}, {8{el[0]}}}), "data");
         host_u.read_strobe(1'b1);
         repeat (5) @(posedge clock_in);
         #1;
         chk(oe_n === 4'hF, "release lanes");
      end
   endtask

   task automatic t_patterns(input logic [1:0] w);
      do_reset(1'b0, w);
      for (int p = 0; p < 16; p++)
         do_access({p[3:0], 11'h2A5}, 1'b0, p[3:0], p[0], 1'b1);
      do_access(15'h1234, 1'b1, 4'hE, 1'b1, 1'b1);
      do_access(15'h4321, 1'b1, 4'h5, 1'b1, 1'b0);
   endtask

   task automatic t_byte_host();
      logic [3:0] pats [4] = '{4'hE, 4'hD, 4'hB, 4'h7};
      do_reset(1'b0, hiu_pkg::HIU_W8);
      foreach (pats[i])
         do_access({4'h9, 11'h100} + 15'(i), 1'b0, pats[i], 1'b1, 1'b1);
   endtask

   task automatic t_sync();
      logic [3:0] pats [4] = '{4'h0, 4'h3, 4'hE, 4'h7};
      do_reset(1'b1, hiu_pkg::HIU_W32);
      foreach (pats[i])
         do_access(15'h3C00 + 15'(i), 1'b0, pats[i], 1'(i), 1'b1);
      do_access(15'h0F0F, 1'b1, 4'hC, 1'b1, 1'b1);
   endtask

   task automatic t_local();
      logic [11:0] bases [3] = '{12'hA5C, 12'hA5D, 12'hA5C};
      logic        quals [3] = '{1'b0, 1'b0, 1'b1};
      host_u.drive_addr({12'hA5C, 3'h5}, 1'b0);
      foreach (bases[i])
      begin
         host_u.drive_addr({12'hA5C, 3'h5}, quals[i]);
         @(posedge clock_in);
         base_addr_in <= bases[i];
         #1;
         chk(local_n === !(quals[i] == 1'b0 && bases[i] == 12'hA5C), "local select");
      end
   endtask

   task automatic summarize();
      if (failures == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      t_patterns(hiu_pkg::HIU_W32);
      t_patterns(hiu_pkg::HIU_W16);
      t_byte_host();
      t_sync();
      t_local();
      summarize();
   end
endmodule
